//--- core/tbs_pkg.sv
package tbs_pkg;
	localparam int unsigned CLK_FREQ_HZ = 40_000_000;
	// byte clock generated in output mode, as system clock divider halves
	localparam int unsigned BYTE_CLK_HALF_HI = 4;
	localparam int unsigned BYTE_CLK_HALF_LO = 16;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned BIT_CNT_W = 3;
	localparam logic [2:0] MSB_INDEX = 3'h7;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	typedef struct packed {
		logic [7:0] data;
	} tbs_byte_t;

	typedef struct packed {
		logic pos;
		logic neg;
	} tbs_diff_t;

	typedef enum logic [1:0] {
		TBS_IDLE = 2'b01,
		TBS_SHIFT = 2'b10
	} tbs_state_t;
endpackage : tbs_pkg

//--- core/tbs_tx_byte_serializer.sv
`timescale 1ns/10ps
// What this block does
// - direction high: drive byte clock out
// - capture byte on rising byte clock edge
// - direction low: byte clock is input
// - shift each byte out msb first
// - serial rate is eight times byte rate
// - reference frequency select picks 77.76/19.44
// - select differential or single-ended reference
module tbs_tx_byte_serializer #(
	parameter int unsigned HALF_HI = tbs_pkg::BYTE_CLK_HALF_HI,
	parameter int unsigned HALF_LO = tbs_pkg::BYTE_CLK_HALF_LO
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic high_rate_mode,
	input wire logic tx_clock_direction_select,
	input wire logic tx_byte_clock_pin_i,
	output logic tx_byte_clock_pin_o,
	output logic tx_byte_clock_pin_oe,
	input wire tbs_pkg::tbs_byte_t tx_parallel_byte,
	input wire logic ref_freq_select,
	input wire logic use_single_ended_ref,
	input wire tbs_pkg::tbs_diff_t diff_ref_clock,
	input wire logic single_ended_ref_clock,
	output logic ref_clock_selected,
	output logic ref_is_high_freq,
	input wire logic bit_ready,
	output logic bit_valid,
	output tbs_pkg::tbs_diff_t serial_out,
	output logic byte_lost
);
	////////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [1:0] dir_sync_reg;
	logic [1:0] pin_sync_reg;
	logic [1:0] rsel_sync_reg;
	logic [1:0] use_se_sync_reg;
	logic [1:0] se_clk_sync_reg;
	logic [1:0] diff_pos_sync_reg;
	logic pin_prev_reg;
	tbs_pkg::tbs_byte_t data_s1_reg;
	tbs_pkg::tbs_byte_t data_s2_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_sync_reg <= 2'h0;
			pin_sync_reg <= 2'h0;
			rsel_sync_reg <= 2'h0;
			use_se_sync_reg <= 2'h0;
			se_clk_sync_reg <= 2'h0;
			diff_pos_sync_reg <= 2'h0;
			pin_prev_reg <= 1'b0;
			data_s1_reg <= tbs_pkg::BYTE_RESET;
			data_s2_reg <= tbs_pkg::BYTE_RESET;
		end else begin
			dir_sync_reg <= {dir_sync_reg[0], tx_clock_direction_select};
			pin_sync_reg <= {pin_sync_reg[0], tx_byte_clock_pin_i};
			rsel_sync_reg <= {rsel_sync_reg[0], ref_freq_select};
			use_se_sync_reg <= {use_se_sync_reg[0], use_single_ended_ref};
			se_clk_sync_reg <= {se_clk_sync_reg[0],
				single_ended_ref_clock};
			diff_pos_sync_reg <= {diff_pos_sync_reg[0],
				diff_ref_clock.pos};
			pin_prev_reg <= pin_sync_reg[1];
			data_s1_reg <= tx_parallel_byte;
			data_s2_reg <= data_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// byte clock divider for output mode
	logic [7:0] div_cnt_reg;
	logic [7:0] div_half;
	logic byte_clk_reg;
	logic gen_rise;
	logic cap_strobe;
	assign div_half = high_rate_mode ? 8'(HALF_HI) : 8'(HALF_LO);
	assign gen_rise = dir_sync_reg[1] && !byte_clk_reg &&
		(div_cnt_reg == div_half - 8'h01);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_reg <= 8'h00;
			byte_clk_reg <= 1'b0;
		end else if (div_cnt_reg >= div_half - 8'h01) begin
			div_cnt_reg <= 8'h00;
			byte_clk_reg <= ~byte_clk_reg;
		end else begin
			div_cnt_reg <= div_cnt_reg + 8'h01;
		end
	end
	assign tx_byte_clock_pin_o = byte_clk_reg;
	assign tx_byte_clock_pin_oe = dir_sync_reg[1];
	// capture on rising edge of whichever byte clock is active
	assign cap_strobe = dir_sync_reg[1] ? gen_rise :
		(pin_sync_reg[1] && !pin_prev_reg);

	////////////////////////////////////////////////////////////////////////
	// reference selection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_clock_selected <= 1'b0;
			ref_is_high_freq <= 1'b0;
		end else begin
			// unused reference input is tied low on the board
			ref_clock_selected <= use_se_sync_reg[1] ?
				se_clk_sync_reg[1] : diff_pos_sync_reg[1];
			ref_is_high_freq <= rsel_sync_reg[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// two-entry byte buffer
	tbs_pkg::tbs_byte_t buf_mem [2];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] count_reg;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_pop;
	logic buf_push;
	assign buf_in_ready = count_reg != 2'h2;
	assign buf_out_valid = count_reg != 2'h0;
	assign buf_push = cap_strobe && buf_in_ready;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg <= 2'h0;
			buf_mem[0] <= tbs_pkg::BYTE_RESET;
			buf_mem[1] <= tbs_pkg::BYTE_RESET;
		end else begin
			if (buf_push) begin
				buf_mem[wr_ptr_reg] <= data_s2_reg;
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (buf_pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			count_reg <= count_reg + 2'(buf_push) - 2'(buf_pop);
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byte_lost <= 1'b0;
		end else begin
			byte_lost <= cap_strobe && !buf_in_ready;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serializer
	tbs_pkg::tbs_state_t state_reg;
	tbs_pkg::tbs_byte_t shift_reg;
	tbs_pkg::tbs_byte_t head_byte;
	logic [2:0] bit_idx_reg;
	logic bit_take;
	logic serial_pos_reg;
	function automatic logic pick_bit(
		input tbs_pkg::tbs_byte_t b,
		input logic [2:0] idx
	);
		return b.data[idx];
	endfunction : pick_bit
	assign head_byte = buf_mem[rd_ptr_reg];
	assign bit_take = bit_valid && bit_ready;
	assign buf_pop = buf_out_valid &&
		(state_reg == tbs_pkg::TBS_IDLE ||
		(bit_take && bit_idx_reg == 3'h0));
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= tbs_pkg::TBS_IDLE;
			shift_reg <= tbs_pkg::BYTE_RESET;
			bit_idx_reg <= tbs_pkg::MSB_INDEX;
		end else begin
			unique case (state_reg)
				tbs_pkg::TBS_IDLE: begin
					if (buf_pop) begin
						shift_reg <= buf_mem[rd_ptr_reg];
						bit_idx_reg <= tbs_pkg::MSB_INDEX;
						state_reg <= tbs_pkg::TBS_SHIFT;
					end
				end
				tbs_pkg::TBS_SHIFT: begin
					if (bit_take) begin
						if (bit_idx_reg == 3'h0) begin
							// exactly eight bits per byte
							if (buf_pop) begin
								shift_reg <= buf_mem[rd_ptr_reg];
								bit_idx_reg <= tbs_pkg::MSB_INDEX;
							end else begin
								state_reg <= tbs_pkg::TBS_IDLE;
							end
						end else begin
							bit_idx_reg <= bit_idx_reg - 3'h1;
						end
					end
				end
			endcase
		end
	end
	assign bit_valid = state_reg == tbs_pkg::TBS_SHIFT;

	////////////////////////////////////////////////////////////////////////
	// registered serial bit, equals the shifter's current bit in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_pos_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				tbs_pkg::TBS_IDLE: begin
					if (buf_pop) begin
						serial_pos_reg <=
							pick_bit(head_byte, tbs_pkg::MSB_INDEX);
					end
				end
				tbs_pkg::TBS_SHIFT: begin
					if (bit_take) begin
						if (bit_idx_reg != 3'h0) begin
							serial_pos_reg <=
								pick_bit(shift_reg, bit_idx_reg - 3'h1);
						end else if (buf_pop) begin
							serial_pos_reg <=
								pick_bit(head_byte, tbs_pkg::MSB_INDEX);
						end else begin
							// line rests low while idle
							serial_pos_reg <= 1'b0;
						end
					end
				end
			endcase
		end
	end
	always_comb begin
		serial_out.pos = serial_pos_reg;
		serial_out.neg = !serial_pos_reg;
	end
endmodule : tbs_tx_byte_serializer

//--- tb/tbs_tx_serializer_asserts.sv
`timescale 1ns/10ps
module tbs_tx_serializer_asserts (
	input logic clk,
	input logic rst_n,
	input logic high_rate_mode,
	input logic tx_clock_direction_select,
	input logic tx_byte_clock_pin_o,
	input logic tx_byte_clock_pin_oe,
	input logic bit_ready,
	input logic bit_valid,
	input tbs_pkg::tbs_diff_t serial_out,
	input logic byte_lost
);
	wire po = tx_byte_clock_pin_o;
	wire dr = tx_clock_direction_select;
	wire oe = tx_byte_clock_pin_oe;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_hi; po[*4] ##1 !po[*4]; endsequence
	property p_hi; $rose(po) && high_rate_mode |-> s_hi; endproperty
	a_hi: assert property (p_hi) else $error("hi");
	property p_lo; $rose(po) && !high_rate_mode |-> po[*8]; endproperty
	a_lo: assert property (p_lo) else $error("lo");
	property p_on; dr[*4] |-> oe; endproperty
	a_on: assert property (p_on) else $error("on");
	property p_off; !dr[*4] |-> !oe; endproperty
	a_off: assert property (p_off) else $error("off");
	property p_dif; serial_out.neg != serial_out.pos; endproperty
	a_dif: assert property (p_dif) else $error("dif");
	property p_idl; !bit_valid |-> !serial_out.pos; endproperty
	a_idl: assert property (p_idl) else $error("idl");
	property p_hld;
		bit_valid && !bit_ready |=> bit_valid && $stable(serial_out);
	endproperty
	a_hld: assert property (p_hld) else $error("hld");
	property p_lst; byte_lost |=> !byte_lost; endproperty
	a_lst: assert property (p_lst) else $error("lst");
endmodule : tbs_tx_serializer_asserts
bind tbs_tx_byte_serializer tbs_tx_serializer_asserts chk_u (.*);

//--- tb/tbs_framer.sv
`timescale 1ns/10ps
module tbs_framer (
	input logic pin,
	input logic en,
	input logic [7:0] nxt,
	output logic fc = 0,
	output tbs_pkg::tbs_byte_t d = '0
);
	always #100 fc = ~fc;
	// launch on falling edge so the rising edge sees settled data
	always @(negedge pin) d <= en ? nxt : 8'h00;
endmodule : tbs_framer

//--- tb/tbs_tx_byte_serializer_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
	miscompares++; $display("Error %0t bad", $time); end end
module tbs_tx_byte_serializer_tb;
	logic clk = 0, rst_n = 0, high_rate_mode, tx_clock_direction_select;
	logic tx_byte_clock_pin_o, tx_byte_clock_pin_oe, ref_freq_select = 0;
	logic use_single_ended_ref = 0, single_ended_ref_clock = 0, bit_ready;
	logic ref_clock_selected, ref_is_high_freq, bit_valid, byte_lost;
	logic fc, en = 0, rm, rs, seen;
	logic [7:0] rnd = 8'h60, sh, q[$];
	logic [2:0] rh;
	int miscompares = 0, checks_done = 0, n, cyc = 0;
	tbs_pkg::tbs_byte_t tx_parallel_byte;
	tbs_pkg::tbs_diff_t diff_ref_clock = 2'h1, serial_out;
	wire tx_byte_clock_pin_i =
		tx_byte_clock_pin_oe ? tx_byte_clock_pin_o : fc;
	tbs_tx_byte_serializer dut_u (.*);
	tbs_framer fr_u (.pin(tx_byte_clock_pin_i), .en, .nxt(rnd), .fc,
		.d(tx_parallel_byte));
	always #12.5 clk = ~clk;
	function automatic logic [7:0] lf(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lf
	task close_out(input int t);
		miscompares += t;
		$display("checks %0d errors %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////
	// rebuild bytes from accepted bits, zero bytes are filler
	always @(posedge clk) begin
		if (++cyc > 9000) close_out(1);
		if (byte_lost) seen = 1;
		if (bit_valid && bit_ready) begin
			sh = {sh[6:0], serial_out.pos};
			n++;
		end
		if (n == 8) begin
			n = 0;
			if (sh != 0) `CHK(sh, q.pop_front())
		end
	end
	always @(posedge tx_byte_clock_pin_i)
		if (tx_parallel_byte != 0) q.push_back(tx_parallel_byte);
	task tick(input int k);
		repeat (k) begin
			@(posedge clk);
			#1;
			// two sync stages plus the output register
			if (rst_n) `CHK(ref_clock_selected, rh[2])
			else rh = 3'h0;
			rnd = lf(rnd);
			diff_ref_clock = {rnd[1], !rnd[1]};
			single_ended_ref_clock = rnd[2];
			rs = use_single_ended_ref ? rnd[2] : rnd[1];
			rh = {rh[1:0], rs};
			if (rm) bit_ready = rnd[0];
		end
	endtask : tick
	task run(input logic h, r, m, y);
		rst_n = 0;
		{high_rate_mode, tx_clock_direction_select, rm, bit_ready} =
			{h, r, m, y};
		seen = 0;
		n = 0;
		ref_freq_select = !ref_freq_select;
		use_single_ended_ref = !use_single_ended_ref;
		q.delete();
		tick(5);
		rst_n = 1;
		tick(10);
		`CHK(tx_byte_clock_pin_oe, r)
		`CHK(ref_is_high_freq, ref_freq_select)
		en = 1;
		tick(1500);
		en = 0;
		tick(200);
		`CHK(q.size() == 0, y)
		`CHK(seen, !y)
	endtask : run
	initial begin
		run(1, 1, 0, 1);
		run(1, 0, 0, 1);
		run(0, 1, 1, 1);
		run(0, 1, 0, 0);
		close_out(0);
	end
endmodule : tbs_tx_byte_serializer_tb
